// File: shared/wsf_defines.svh
// Constants of the section framer: framing values, field codes, defaults.
// Assumes inclusion by bare name; holds definitions only.
`ifndef WSF_DEFINES_SVH
`define WSF_DEFINES_SVH

// Framing octet values
`define WSF_A1_VALUE 8'hf6
`define WSF_A2_VALUE 8'h28
// Octets of each framing kind sent per frame
`define WSF_TX_ONE_COUNT 9'h0c0
`define WSF_TX_TWO_COUNT 9'h0c0
// Line remote defect code in the low K2 bits
`define WSF_RDI_L_CODE 3'h6
`define WSF_K2_FIELD_MSB 2
// Payload forced under AIS-L
`define WSF_AIS_PAYLOAD 8'hff
// Frame length in octets of the aggregate signal
`define WSF_FRAME_OCTETS 155520
// Power-up defaults of the framing controls
`define WSF_DEF_SYNC_WIDTH 5'h02
`define WSF_DEF_HUNT_WIDTH 5'h04
`define WSF_DEF_PRESYNC_A1 5'h10
`define WSF_DEF_PRESYNC_A2 5'h10
`define WSF_DEF_ENTRY_COUNT 4'h4
`define WSF_DEF_EXIT_COUNT 4'h4
// Pattern width ceiling and run counter saturation
`define WSF_MAX_WIDTH 5'h10
`define WSF_RUN_MAX 5'h1f
// Event bit slots
`define WSF_EV_ERRF 0
`define WSF_EV_SIGL 1
`define WSF_EV_CARRIER 2
`define WSF_EV_COUNT 3

`endif

// File: shared/wsf_pkg.sv
// Types shared by the section framer modules.
// Assumes nothing of its surroundings.
package wsf_pkg;
  // Primary framer states; every state but sync is out of frame
  typedef enum logic [1:0] {
    wsf_hunt,
    wsf_presync_seek,
    wsf_presync_confirm,
    wsf_sync
  } wsf_frm_state_t;
endpackage

// File: rtl/wsf_pattern_match.sv
// Run matcher: flags the octet that completes a run of A1 then A2 octets.
// Assumes octets already aligned on byte lanes; hit is combinational.
`timescale 1ns/1ps
`default_nettype none
`include "wsf_defines.svh"

module wsf_pattern_match (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic [7:0] octet, // Incoming octet
  input wire logic octet_valid, // Octet present
  input wire logic [4:0] need_a1, // A1 octets required
  input wire logic [4:0] need_a2, // A2 octets required, zero means nibble
  output logic hit, // Pattern ends on this octet
  output logic [4:0] a1_run // A1 octets seen in a row
);
  logic [4:0] a2_run; // A2 octets after the A1 run
  logic [4:0] a1_hold; // A1 run frozen at the first A2
  wire is_a1 = (octet == `WSF_A1_VALUE);
  wire is_a2 = (octet == `WSF_A2_VALUE);
  wire a2_follows = is_a2 && ((a2_run != 5'h00) || (a1_run != 5'h00));
  wire [4:0] a1_seen = (a2_run == 5'h00) ? a1_run : a1_hold;
  wire [4:0] a2_next = (a2_run == `WSF_RUN_MAX) ? a2_run : a2_run + 5'h01;
  // Nibble form checks only the top half of the first A2 octet
  wire nibble_hit = (octet[7:4] == `WSF_A2_VALUE >> 4) && (a2_run == 5'h00) && (a1_run >= need_a1);
  wire full_hit = a2_follows && (a2_next == need_a2) && (a1_seen >= need_a1);

  assign hit = octet_valid && ((need_a2 == 5'h00) ? nibble_hit : full_hit);

  // Run counters; any other octet breaks both runs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a1_run <= 5'h00;
      a2_run <= 5'h00;
      a1_hold <= 5'h00;
    end else if (octet_valid) begin
      if (is_a1) begin
        a1_run <= (a1_run == `WSF_RUN_MAX) ? a1_run : a1_run + 5'h01;
        a2_run <= 5'h00;
      end else if (a2_follows) begin
        if (a2_run == 5'h00) begin
          a1_hold <= a1_run;
        end
        a1_run <= 5'h00;
        a2_run <= a2_next;
      end else begin
        a1_run <= 5'h00;
        a2_run <= 5'h00;
      end
    end
  end
endmodule

`default_nettype wire

// File: rtl/wsf_event_bit.sv
// One alarm: latch-high status and a sticky pending bit.
// Assumes read strobes are one-cycle pulses from the station manager side.
`timescale 1ns/1ps
`default_nettype none

module wsf_event_bit #(
  parameter logic RST_STATUS = 1'b0 // Status level shown in reset
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic condition, // Present alarm level
  input wire logic event_pulse, // Alarm event
  input wire logic status_read, // Status read strobe
  input wire logic pending_read, // Pending read strobe
  output logic latched_status, // Latch-high status
  output logic pending // Sticky pending
);
  // A read reloads the present level; an event in that cycle still sets
  wire next_status = status_read ? (condition | event_pulse) : (latched_status | condition | event_pulse);
  wire next_pending = event_pulse | (pending & ~pending_read);

  // Both bits update every cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched_status <= RST_STATUS;
      pending <= 1'b0;
    end else begin
      latched_status <= next_status;
      pending <= next_pending;
    end
  end
endmodule

`default_nettype wire

// File: rtl/wsf_section_framer.sv
// Section framer: A1/A2 sourcing, receive frame aligner, SEVERELY_ERRORED_FRAME, LOSS_OF_SIGNAL and
// carrier-loss alarms with consequent actions and two interrupt outputs.
// Assumes octet-wide streams, frame start marks from the overhead generator.
`timescale 1ns/1ps
`default_nettype none
`include "wsf_defines.svh"

module wsf_section_framer #(
  parameter int FRAME_OCTETS = `WSF_FRAME_OCTETS // Octets per frame
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic sys_rst, // Async reset, high
  input wire logic [7:0] tx_in_octet, // Transmit octet from overhead path
  input wire logic tx_in_valid, // Transmit octet present
  input wire logic tx_frame_start, // First framing octet of a frame
  input wire logic tx_is_k2, // This octet is K2
  input wire logic [7:0] tx_frame_octet_one, // Programmed A1 value
  input wire logic [7:0] tx_frame_octet_two, // Programmed A2 value
  output logic [7:0] tx_out_octet, // Transmit octet toward PMA
  output logic tx_out_valid, // Transmit octet present
  input wire logic [7:0] rx_in_octet, // Receive octet from PMA
  input wire logic rx_in_valid, // Receive octet present
  output logic [7:0] rx_out_octet, // Receive octet toward PCS
  output logic rx_out_valid, // Receive octet present
  input wire logic [4:0] sync_pattern_width, // f, 0 to 16
  input wire logic [4:0] hunt_pattern_width, // i, 1 to 16
  input wire logic [4:0] presync_a1_width, // j, 0 to 31
  input wire logic [4:0] presync_a2_width, // k, 0 to 31
  input wire logic [3:0] sync_entry_count, // Entry count, 0 to 15
  input wire logic [3:0] sync_exit_count, // Exit count, 0 to 15
  input wire logic loss_of_signal, // Line signal lost, high
  input wire logic optical_carrier_loss_input, // Optics carrier loss pin
  input wire logic carrier_loss_polarity_select, // High: pin active low
  input wire logic tx_rdi_on_signal_loss, // RDI-L on signal loss
  input wire logic rx_ais_on_signal_loss, // AIS-L on signal loss
  input wire logic tx_rdi_on_carrier_loss, // RDI-L on carrier loss
  input wire logic rx_frame_loss_on_carrier_loss, // Force frame loss
  input wire logic rx_ais_on_carrier_loss, // AIS-L on carrier loss
  input wire logic errored_frame_mask_a, // SEVERELY_ERRORED_FRAME to output A
  input wire logic errored_frame_mask_b, // SEVERELY_ERRORED_FRAME to output B
  input wire logic signal_loss_mask_a, // LOSS_OF_SIGNAL to output A
  input wire logic signal_loss_mask_b, // LOSS_OF_SIGNAL to output B
  input wire logic carrier_loss_mask_a, // Carrier to output A
  input wire logic carrier_loss_mask_b, // Carrier to output B
  input wire logic errored_frame_status_read, // Read of SEVERELY_ERRORED_FRAME status
  input wire logic signal_loss_status_read, // Read of LOSS_OF_SIGNAL status
  input wire logic errored_frame_pending_read, // Read of SEVERELY_ERRORED_FRAME pending
  input wire logic signal_loss_pending_read, // Read of LOSS_OF_SIGNAL pending
  input wire logic carrier_loss_pending_read, // Read of carrier pending
  output logic out_of_frame_state, // Framer not in sync
  output logic severely_errored_frame, // Latched SEVERELY_ERRORED_FRAME status
  output logic loss_of_frame, // Frame loss alarm
  output logic signal_loss_status, // Latched LOSS_OF_SIGNAL status
  output logic errored_frame_pending, // SEVERELY_ERRORED_FRAME pending
  output logic signal_loss_pending, // LOSS_OF_SIGNAL pending
  output logic carrier_loss_pending, // Carrier pending
  output logic carrier_loss_live_status, // Carrier loss, polarity fixed
  output logic ais_line_alarm, // AIS-L asserted
  output logic interrupt_out_a, // Interrupt A, high
  output logic interrupt_out_b // Interrupt B, high
);
  // Width 0 acts as 1 for the presync A1 run, the sync A1 run and the hunt run
  function automatic logic [4:0] floor_one(input logic [4:0] w);
    floor_one = (w == 5'h00) ? 5'h01 : w;
  endfunction

  // Widths of 17 to 31 act as 16
  function automatic logic [4:0] cap_sixteen(input logic [4:0] w);
    cap_sixteen = (w > `WSF_MAX_WIDTH) ? `WSF_MAX_WIDTH : w;
  endfunction

  // Count of 0 acts as 1
  function automatic logic [3:0] count_floor(input logic [3:0] c);
    count_floor = (c == 4'h0) ? 4'h1 : c;
  endfunction

  // Transmit side
  logic [8:0] tx_pos; // Framing octet index
  logic tx_in_frame; // Within the framing octet block
  logic carrier_loss; // Carrier loss, polarity corrected
  wire tx_rdi = (tx_rdi_on_signal_loss & loss_of_signal) | (tx_rdi_on_carrier_loss & carrier_loss);
  wire [8:0] tx_index = tx_frame_start ? 9'h000 : tx_pos;
  wire tx_framing = tx_frame_start | tx_in_frame;
  wire tx_send_a1 = tx_framing && (tx_index < `WSF_TX_ONE_COUNT);
  wire tx_send_a2 = tx_framing && !tx_send_a1;
  wire tx_last = tx_index == (`WSF_TX_ONE_COUNT + `WSF_TX_TWO_COUNT - 9'h001);
  wire [7:0] tx_k2_rdi = {tx_in_octet[7:`WSF_K2_FIELD_MSB + 1], `WSF_RDI_L_CODE};
  wire [7:0] next_tx_octet = tx_send_a1 ? tx_frame_octet_one :
                             tx_send_a2 ? tx_frame_octet_two :
                             (tx_is_k2 && tx_rdi) ? tx_k2_rdi :
                             tx_in_octet;

  // Framing octet counter: 192 A1 then 192 A2 after each frame start
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pos <= 9'h000;
      tx_in_frame <= 1'b0;
    end else if (tx_in_valid && tx_framing) begin
      tx_pos <= tx_index + 9'h001;
      tx_in_frame <= !tx_last;
    end
  end

  // Transmit output stage; an idle cycle keeps the last octet
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_out_octet <= 8'h00;
      tx_out_valid <= 1'b0;
    end else begin
      tx_out_valid <= tx_in_valid;
      if (tx_in_valid) begin
        tx_out_octet <= next_tx_octet;
      end
    end
  end

  // Secondary machine: run matchers for the presync and sync patterns
  logic presync_hit; // Presync pattern ends here
  logic sync_hit; // Sync pattern ends here
  logic [4:0] a1_run; // Consecutive A1 count
  wire [4:0] f_width = cap_sixteen(sync_pattern_width);
  // f of 1 means A1A1A2; f of 0 means A1 plus the A2 top nibble
  wire [4:0] sync_need_a1 = (f_width == 5'h01) ? 5'h02 : floor_one(f_width);
  wire [4:0] sync_need_a2 = f_width;
  wire [4:0] pre_need_a1 = floor_one(cap_sixteen(presync_a1_width));
  wire [4:0] pre_need_a2 = cap_sixteen(presync_a2_width);
  wire [4:0] hunt_need = floor_one(cap_sixteen(hunt_pattern_width));

  // Presync matcher also supplies the A1 run for the hunt
  wsf_pattern_match u_presync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .octet(rx_in_octet),
    .octet_valid(rx_in_valid),
    .need_a1(pre_need_a1),
    .need_a2(pre_need_a2),
    .hit(presync_hit),
    .a1_run(a1_run)
  );

  // Sync matcher checks each expected frame boundary
  wsf_pattern_match u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .octet(rx_in_octet),
    .octet_valid(rx_in_valid),
    .need_a1(sync_need_a1),
    .need_a2(sync_need_a2),
    .hit(sync_hit),
    .a1_run()
  );

  // Primary machine
  wsf_pkg::wsf_frm_state_t frm_state; // Present framer state
  wsf_pkg::wsf_frm_state_t next_frm_state; // Framer state to come
  logic [17:0] frm_pos; // Octets since the last boundary
  logic [3:0] good_count; // Boundaries found since presync
  logic [3:0] bad_count; // Errored alignment words in a row
  wire force_loss = rx_frame_loss_on_carrier_loss & carrier_loss;
  wire hunt_found = rx_in_valid && ((a1_run >= hunt_need) ||
                    ((rx_in_octet == `WSF_A1_VALUE) && (a1_run + 5'h01 >= hunt_need)));
  wire at_boundary = rx_in_valid && (frm_pos == FRAME_OCTETS[17:0]);
  wire [3:0] entry_goal = count_floor(sync_entry_count);
  wire [3:0] exit_goal = count_floor(sync_exit_count);
  wire confirm_done = at_boundary && sync_hit && ({1'b0, good_count} >= {1'b0, entry_goal});
  wire exit_now = at_boundary && !sync_hit && (bad_count + 4'h1 >= exit_goal);

  // State choice; carrier loss can pin the framer in hunt
  always_comb begin
    next_frm_state = frm_state;
    case (frm_state)
      wsf_pkg::wsf_hunt: begin
        if (hunt_found) begin
          next_frm_state = wsf_pkg::wsf_presync_seek;
        end
      end
      wsf_pkg::wsf_presync_seek: begin
        if (presync_hit) begin
          next_frm_state = wsf_pkg::wsf_presync_confirm;
        end else if (at_boundary) begin
          next_frm_state = wsf_pkg::wsf_hunt; // No presync within a frame
        end
      end
      wsf_pkg::wsf_presync_confirm: begin
        if (confirm_done) begin
          next_frm_state = wsf_pkg::wsf_sync;
        end else if (at_boundary && !sync_hit) begin
          next_frm_state = wsf_pkg::wsf_hunt;
        end
      end
      wsf_pkg::wsf_sync: begin
        if (exit_now) begin
          next_frm_state = wsf_pkg::wsf_hunt;
        end
      end
      default: begin
        next_frm_state = wsf_pkg::wsf_hunt;
      end
    endcase
    if (force_loss) begin
      next_frm_state = wsf_pkg::wsf_hunt;
    end
  end

  // State register; reset lands out of frame
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frm_state <= wsf_pkg::wsf_hunt;
    end else begin
      frm_state <= next_frm_state;
    end
  end

  // Boundary position: restarted at every expected boundary and on the hunt and presync finds
  wire pos_restart = ((frm_state == wsf_pkg::wsf_hunt) && hunt_found) ||
                     ((frm_state == wsf_pkg::wsf_presync_seek) && presync_hit) || at_boundary;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frm_pos <= 18'h00001;
    end else if (rx_in_valid) begin
      frm_pos <= pos_restart ? 18'h00001 : frm_pos + 18'h00001;
    end
  end

  // Boundary counts; the presync find counts as the first boundary
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      good_count <= 4'h0;
      bad_count <= 4'h0;
    end else begin
      if ((frm_state == wsf_pkg::wsf_presync_seek) && presync_hit) begin
        good_count <= 4'h1;
      end else if ((frm_state == wsf_pkg::wsf_presync_confirm) && at_boundary && sync_hit) begin
        good_count <= good_count + 4'h1;
      end
      if (frm_state != wsf_pkg::wsf_sync) begin
        bad_count <= 4'h0;
      end else if (at_boundary) begin
        bad_count <= sync_hit ? 4'h0 : bad_count + 4'h1;
      end
    end
  end

  // Alarm levels; frame loss follows out of frame here, its integration lives elsewhere
  logic errf_cond; // Severely errored frame condition
  logic carrier_pin_prev; // Pin level one cycle ago
  wire enter_unfrm = (frm_state == wsf_pkg::wsf_sync) && (next_frm_state != wsf_pkg::wsf_sync);
  wire entering_sync = (frm_state != wsf_pkg::wsf_sync) && (next_frm_state == wsf_pkg::wsf_sync);
  wire carrier_now = optical_carrier_loss_input ^ carrier_loss_polarity_select;
  wire ais_now = (rx_ais_on_signal_loss & loss_of_signal) | (rx_ais_on_carrier_loss & carrier_loss);
  logic sig_prev; // Signal loss one cycle ago

  // Alarm state; SEVERELY_ERRORED_FRAME and frame loss start active after reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      errf_cond <= 1'b1;
      loss_of_frame <= 1'b1;
      out_of_frame_state <= 1'b1;
      carrier_loss <= 1'b0;
      carrier_loss_live_status <= 1'b0;
      carrier_pin_prev <= 1'b0;
      sig_prev <= 1'b0;
      ais_line_alarm <= 1'b0;
    end else begin
      if (enter_unfrm) begin
        errf_cond <= 1'b1;
      end else if (entering_sync) begin
        errf_cond <= 1'b0;
      end
      out_of_frame_state <= (next_frm_state != wsf_pkg::wsf_sync);
      loss_of_frame <= (next_frm_state != wsf_pkg::wsf_sync) | force_loss;
      carrier_loss <= carrier_now;
      carrier_loss_live_status <= carrier_now;
      carrier_pin_prev <= optical_carrier_loss_input;
      sig_prev <= loss_of_signal; // Raw level, no hysteresis
      ais_line_alarm <= ais_now;
    end
  end

  // Event bits: SEVERELY_ERRORED_FRAME, LOSS_OF_SIGNAL and carrier in three slots; SEVERELY_ERRORED_FRAME status resets high, carrier status has no read
  logic [`WSF_EV_COUNT-1:0] ev_cond; // Present levels
  logic [`WSF_EV_COUNT-1:0] ev_pulse; // Events
  logic [`WSF_EV_COUNT-1:0] ev_sread; // Status reads
  logic [`WSF_EV_COUNT-1:0] ev_pread; // Pending reads
  logic [`WSF_EV_COUNT-1:0] ev_status; // Latched status
  logic [`WSF_EV_COUNT-1:0] ev_pend; // Pending bits
  logic [`WSF_EV_COUNT-1:0] mask_a; // Output A enables
  logic [`WSF_EV_COUNT-1:0] mask_b; // Output B enables
  assign ev_cond = {carrier_loss, loss_of_signal, errf_cond | enter_unfrm};
  assign ev_pulse = {optical_carrier_loss_input ^ carrier_pin_prev,
                     loss_of_signal & ~sig_prev,
                     enter_unfrm};
  assign ev_sread = {1'b0, signal_loss_status_read, errored_frame_status_read};
  assign ev_pread = {carrier_loss_pending_read, signal_loss_pending_read, errored_frame_pending_read};
  assign mask_a = {carrier_loss_mask_a, signal_loss_mask_a, errored_frame_mask_a};
  assign mask_b = {carrier_loss_mask_b, signal_loss_mask_b, errored_frame_mask_b};

  // Latch-high status and sticky pending per slot
  genvar g;
  generate
    for (g = 0; g < `WSF_EV_COUNT; g = g + 1) begin : g_event
      wsf_event_bit #(
        .RST_STATUS(g == `WSF_EV_ERRF)
      ) u_bit (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .condition(ev_cond[g]),
        .event_pulse(ev_pulse[g]),
        .status_read(ev_sread[g]),
        .pending_read(ev_pread[g]),
        .latched_status(ev_status[g]),
        .pending(ev_pend[g])
      );
    end
  endgenerate

  assign severely_errored_frame = ev_status[`WSF_EV_ERRF];
  assign signal_loss_status = ev_status[`WSF_EV_SIGL];
  assign errored_frame_pending = ev_pend[`WSF_EV_ERRF];
  assign signal_loss_pending = ev_pend[`WSF_EV_SIGL];
  assign carrier_loss_pending = ev_pend[`WSF_EV_CARRIER];

  // Interrupt outputs follow masked pending bits, one cycle behind
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_out_a <= 1'b0;
      interrupt_out_b <= 1'b0;
    end else begin
      interrupt_out_a <= |(ev_pend & mask_a);
      interrupt_out_b <= |(ev_pend & mask_b);
    end
  end

  // Receive payload stage; AIS-L overwrites every octet with ones
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_out_octet <= 8'h00;
      rx_out_valid <= 1'b0;
    end else begin
      rx_out_valid <= rx_in_valid;
      if (rx_in_valid) begin
        rx_out_octet <= ais_now ? `WSF_AIS_PAYLOAD : rx_in_octet;
      end
    end
  end
endmodule

`default_nettype wire

// File: bench/wsf_section_framer_assertions.sv
// Concurrent checks on the section framer ports: alarms, interrupts, framer.
// Assumes a bind from the bench; one clock domain, reset async and high.
`timescale 1ns/1ps
`default_nettype none
`include "wsf_defines.svh"
module wsf_section_framer_assertions (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic loss_of_signal, // Line signal lost
  input wire logic signal_loss_pending, // Signal loss pending
  input wire logic signal_loss_pending_read, // Pending read strobe
  input wire logic signal_loss_mask_a, // Signal loss to output A
  input wire logic interrupt_out_a, // Interrupt A
  input wire logic errored_frame_pending, // Errored frame pending
  input wire logic errored_frame_mask_b, // Errored frame to output B
  input wire logic interrupt_out_b, // Interrupt B
  input wire logic out_of_frame_state, // Framer not in sync
  input wire logic severely_errored_frame, // Latched errored frame status
  input wire logic loss_of_frame, // Frame loss alarm
  input wire logic rx_in_valid, // Receive octet present
  input wire logic rx_ais_on_signal_loss, // AIS-L on signal loss
  input wire logic [7:0] rx_out_octet, // Receive octet toward PCS
  input wire logic optical_carrier_loss_input, // Carrier loss pin
  input wire logic carrier_loss_pending // Carrier pending
);
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  loss_pend_set_a: assert property ($rose(loss_of_signal) |=> signal_loss_pending)
    else $error("loss pend unset");
  loss_pend_hold_a: assert property (signal_loss_pending && !signal_loss_pending_read |=> signal_loss_pending)
    else $error("loss pend lost");
  int_a_mask_a: assert property (signal_loss_pending && signal_loss_mask_a |=> interrupt_out_a)
    else $error("int A missing");
  int_b_mask_a: assert property (errored_frame_pending && errored_frame_mask_b |=> interrupt_out_b)
    else $error("int B missing");
  errf_unframed_a: assert property (out_of_frame_state |=> severely_errored_frame)
    else $error("errored frame low");
  floss_unframed_a: assert property (out_of_frame_state |-> loss_of_frame)
    else $error("frame loss low");
  ais_payload_a: assert property (rx_in_valid && rx_ais_on_signal_loss && loss_of_signal
    |=> rx_out_octet == `WSF_AIS_PAYLOAD) else $error("payload not ones");
  carrier_pend_a: assert property ($changed(optical_carrier_loss_input) |-> ##2 carrier_loss_pending)
    else $error("carrier pend unset");
endmodule
`default_nettype wire

// File: bench/wsf_line_partner.sv
// Far line terminal: 64-octet frames, four A1 then four A2, then a ramp.
// Assumes octet-aligned delivery.
`timescale 1ns/1ps
`default_nettype none
`include "wsf_defines.svh"
module wsf_line_partner (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic frame_ok, // Low: framing octets sent as zero
  output logic [7:0] octet, // Line octet
  output logic valid // Octet present
);
  logic [5:0] pos; // Position in frame
  assign valid = !sys_rst; // Line runs free out of reset
  // Ramp never imitates a framing octet
  assign octet = (!frame_ok && pos < 6'h08) ? 8'h00 : pos < 6'h04 ? `WSF_A1_VALUE :
    pos < 6'h08 ? `WSF_A2_VALUE : {2'b10, pos};
  // Position counter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pos <= 6'h00;
    else pos <= pos + 6'h01;
  end
endmodule
`default_nettype wire

// File: bench/wsf_section_framer_bench.sv
// Section framer bench.
// Assumes partner and checker; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "wsf_defines.svh"
module wsf_section_framer_bench;
  logic sys_clk, sys_rst, tx_in_valid, tx_frame_start, tx_is_k2, rx_in_valid, rx_out_valid, tx_out_valid, frame_ok;
  logic [7:0] tx_in_octet, tx_frame_octet_one, tx_frame_octet_two, tx_out_octet, rx_in_octet, rx_out_octet;
  logic [4:0] sync_pattern_width, hunt_pattern_width, presync_a1_width, presync_a2_width;
  logic [3:0] sync_entry_count, sync_exit_count;
  logic loss_of_signal, optical_carrier_loss_input, carrier_loss_polarity_select, tx_rdi_on_signal_loss;
  logic rx_ais_on_signal_loss, tx_rdi_on_carrier_loss, rx_frame_loss_on_carrier_loss, rx_ais_on_carrier_loss;
  logic errored_frame_mask_a, errored_frame_mask_b, signal_loss_mask_a, signal_loss_mask_b, carrier_loss_mask_a;
  logic carrier_loss_mask_b, errored_frame_status_read, signal_loss_status_read, errored_frame_pending_read;
  logic signal_loss_pending_read, carrier_loss_pending_read, out_of_frame_state, severely_errored_frame;
  logic loss_of_frame, signal_loss_status, errored_frame_pending, signal_loss_pending, carrier_loss_pending;
  logic carrier_loss_live_status, ais_line_alarm, interrupt_out_a, interrupt_out_b;
  logic [7:0] txq[$]; // Expected transmit octets
  logic [7:0] d;
  int failures, checks, seed, n;
  wsf_section_framer #(.FRAME_OCTETS(64)) dut (.*);
  wsf_line_partner line (.sys_clk, .sys_rst, .frame_ok, .octet(rx_in_octet), .valid(rx_in_valid));
  always #4 sys_clk = ~sys_clk; // 125 MHz
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Read strobe, then settle
  task automatic pulse(ref logic r);
    @(negedge sys_clk) r = 1'b1;
    @(negedge sys_clk) r = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Bounded state wait
  task wait_oof(input logic v);
    for (int t = 0; t < 3000 && out_of_frame_state !== v; t++) @(negedge sys_clk);
    check("out of frame", out_of_frame_state, v);
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Transmit monitor
  always @(negedge sys_clk) if (tx_out_valid === 1'b1) check("tx", tx_out_octet, txq.pop_front());
  // Watchdog
  initial begin
    #300000;
    failures++;
    final_report;
  end
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    frame_ok = 1'b1;
    {tx_in_valid, tx_frame_start, tx_is_k2, tx_in_octet, loss_of_signal, optical_carrier_loss_input} = '0;
    {carrier_loss_polarity_select, tx_rdi_on_carrier_loss, rx_frame_loss_on_carrier_loss, rx_ais_on_carrier_loss} = '0;
    {errored_frame_status_read, signal_loss_status_read, errored_frame_pending_read} = '0;
    {signal_loss_pending_read, carrier_loss_pending_read} = '0;
    {errored_frame_mask_a, errored_frame_mask_b, signal_loss_mask_a, signal_loss_mask_b} = '1;
    {carrier_loss_mask_a, carrier_loss_mask_b, tx_rdi_on_signal_loss, rx_ais_on_signal_loss} = '1;
    {sync_pattern_width, hunt_pattern_width, presync_a1_width, presync_a2_width} = {5'h04, 5'h04, 5'h04, 5'h04};
    {sync_entry_count, sync_exit_count} = 8'h12;
    seed = 32'hbf97;
    tx_frame_octet_one = 8'($random(seed));
    tx_frame_octet_two = 8'($random(seed));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    check("out of frame", out_of_frame_state, 8'h01);
    check("errored frame", severely_errored_frame, 8'h01);
    loss_of_signal = 1'b1;
    // Framing block, then K2 under signal loss
    for (n = 0; n < 400; n++) begin
      @(negedge sys_clk);
      d = 8'($random(seed));
      tx_in_octet = d;
      tx_in_valid = 1'b1;
      tx_frame_start = (n == 0);
      tx_is_k2 = (n == 390);
      txq.push_back(n < 192 ? tx_frame_octet_one : n < 384 ? tx_frame_octet_two :
        n == 390 ? {d[7:3], `WSF_RDI_L_CODE} : d);
    end
    @(negedge sys_clk) tx_in_valid = 1'b0;
    check("ais alarm", ais_line_alarm, 8'h01);
    check("rx payload", rx_out_octet, 8'hff);
    loss_of_signal = 1'b0;
    check("loss pending", signal_loss_pending, 8'h01);
    check("interrupt a", interrupt_out_a, 8'h01);
    check("loss status", signal_loss_status, 8'h01);
    pulse(signal_loss_status_read);
    check("loss status", signal_loss_status, 8'h00);
    pulse(signal_loss_pending_read);
    check("loss pending", signal_loss_pending, 8'h00);
    check("interrupt a", interrupt_out_a, 8'h00);
    wait_oof(1'b0);
    check("errored frame", severely_errored_frame, 8'h01);
    pulse(errored_frame_status_read);
    check("errored frame", severely_errored_frame, 8'h00);
    // Carrier loss, then polarity flip
    rx_frame_loss_on_carrier_loss = 1'b1;
    optical_carrier_loss_input = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("frame loss", loss_of_frame, 8'h01);
    check("carrier live", carrier_loss_live_status, 8'h01);
    check("carrier pending", carrier_loss_pending, 8'h01);
    carrier_loss_polarity_select = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("carrier live", carrier_loss_live_status, 8'h00);
    wait_oof(1'b0);
    pulse(errored_frame_pending_read);
    check("errored pending", errored_frame_pending, 8'h00);
    frame_ok = 1'b0;
    wait_oof(1'b1);
    repeat (2) @(negedge sys_clk);
    check("errored pending", errored_frame_pending, 8'h01);
    check("interrupt b", interrupt_out_b, 8'h01);
    // Masks off
    {errored_frame_mask_a, errored_frame_mask_b, signal_loss_mask_a, signal_loss_mask_b} = '0;
    {carrier_loss_mask_a, carrier_loss_mask_b} = '0;
    repeat (2) @(negedge sys_clk);
    check("interrupt a", interrupt_out_a, 8'h00);
    check("interrupt b", interrupt_out_b, 8'h00);
    final_report;
  end
endmodule
bind wsf_section_framer wsf_section_framer_assertions chk (.*);
`default_nettype wire
